// file: design/clock_startup_pkg.sv
// Purpose: Shared constants and carrier types for the clock source and start-up control.
// Assumes: Fuse codes arrive in their stored form, where a one means unprogrammed.
// Notes:   All counts are in cycles of the clock that the respective phase watches.
package clock_startup_pkg;

   // Clock source select codes and decoded source kinds.
   localparam logic [3:0] SEL_EXTERNAL   = 4'h0;
   localparam logic [3:0] SEL_RESERVED   = 4'h1;
   localparam logic [3:0] SEL_CAL_RC     = 4'h2;
   localparam logic [3:0] SEL_RC_128K    = 4'h3;
   localparam logic [2:0] MODE_LP_LOWEST = 3'h4;

   typedef enum logic [2:0] {
      SRC_EXTERNAL  = 3'h0,
      SRC_RESERVED  = 3'h1,
      SRC_CAL_RC    = 3'h2,
      SRC_RC_128K   = 3'h3,
      SRC_LOW_FREQ  = 3'h4,
      SRC_FULL_SWNG = 3'h5,
      SRC_LOW_POWER = 3'h6
   } source_e;

   // Fuse word as it travels through the block.
   typedef struct packed {
      logic       divide_by_eight_fuse;
      logic [1:0] startup_time_fuses;
      logic [3:0] clock_source_select_fuses;
   } fuse_s;

   // Shipped fuse state: calibrated RC, start-up code 10, divide-by-eight programmed.
   localparam fuse_s FUSE_DEFAULT = '{1'b0, 2'h2, 4'h2};

   // Time-out lengths in watchdog oscillator cycles, and the fixed extra oscillator cycles.
   localparam int TOUT_NONE_CYCLES  = 0;
   localparam int TOUT_SHORT_CYCLES = 512;
   localparam int TOUT_LONG_CYCLES  = 8192;
   localparam int EXTRA_CK_CYCLES   = 14;

   // Stabilisation counts in oscillator cycles.
   localparam logic [15:0] STAB_EXT   = 16'h0006;
   localparam logic [15:0] STAB_258   = 16'h0102;
   localparam logic [15:0] STAB_1K    = 16'h0400;
   localparam logic [15:0] STAB_16K   = 16'h4000;
   localparam logic [15:0] STAB_32K   = 16'h8000;

   // Last prescaler count, giving a ratio of eight when divide-by-eight is programmed.
   localparam logic [2:0] DIV8_LAST = 3'h7;

   // Register indices on the plain register port.
   localparam logic [1:0] REG_CLOCK_GATE = 2'h0;
   localparam logic [1:0] REG_POWER_CTRL = 2'h1;
   localparam logic [1:0] REG_STATUS     = 2'h2;
   localparam logic [1:0] REG_FUSE_VIEW  = 2'h3;

   // Gate register layout and its value after reset.
   localparam int GATE_CORE   = 0;
   localparam int GATE_PERIPH = 1;
   localparam int GATE_FLASH  = 2;
   localparam int GATE_ASYNC  = 3;
   localparam int GATE_CONV   = 4;
   localparam logic [4:0] GATE_RESET = 5'h1f;

   // Power control bits.
   localparam int PWR_SLEEP     = 0;
   localparam int PWR_CLEAR_INT = 1;

endpackage

// file: design/clock_source_startup_control.sv
// Purpose: Fuse-driven clock source decode, reset time-out, oscillator stabilisation and
//          per-domain clock enables for a small microcontroller.
// Assumes: CLK is 50 MHz and faster than every oscillator pin it samples.
// Notes:   Domain clocks are one-cycle enables of CLK, so gating them cannot glitch.
//
// Function
// - Core enable halted stops core work.
// - Peripheral enable; async interrupt latch always works.
// - Flash enable follows the core enable.
// - Async timer paced by its own oscillator.
// - Converter enable stays on while others halt.
// - Decode four-bit clock source select field.
// - Fuse one means unprogrammed, zero programmed.
// - Default fuses: calibrated RC, divide by eight.
// - Hold internal reset for watchdog-timed delay.
// - Time-out of 0, 512 or 8192 cycles.
// - Count oscillator cycles before releasing reset.
// - Stabilisation from 6 to 32K cycles.
// - Reset uses both phases, wake only stabilisation.
// - Low-power crystal mode from upper three bits.
// - Table for low select bit zero.
// - Table for low select bit one.
// - Divide-by-eight fuse divides system clock.
`timescale 1ns/1ps
module clock_source_startup_control
   import clock_startup_pkg::*;
#(
   parameter int TOUT_SHORT = TOUT_SHORT_CYCLES,
   parameter int TOUT_LONG  = TOUT_LONG_CYCLES
) (
   // Clock and reset.
   input  wire logic       CLK,
   input  wire logic       RST_N,
   // Oscillator and event pins, all asynchronous to CLK.
   input  wire logic       SYS_OSC_IN,
   input  wire logic       WDT_OSC_IN,
   input  wire logic       ASY_OSC_IN,
   input  wire logic       WAKE_IN,
   input  wire logic       EXT_INT_IN,
   // Fuse pins in stored form.
   input  wire fuse_s      FUSE_IN,
   // Register port.
   input  wire logic [1:0] ADDR,
   input  wire logic [7:0] WR_DATA,
   input  wire logic       WR_EN,
   input  wire logic       RD_EN,
   output logic      [7:0] RD_DATA,
   // Reset and domain enables.
   output logic            INTERNAL_RESET_N,
   output logic            CORE_CLK_EN,
   output logic            PERIPH_CLK_EN,
   output logic            FLASH_CLK_EN,
   output logic            ASYNC_CLK_EN,
   output logic            CONV_CLK_EN,
   // Status.
   output logic            ASYNC_INT_PENDING,
   output logic      [1:0] OSC_RANGE
);

   // Start-up sequencer states, Gray coded along reset to run.
   typedef enum logic [2:0] {
      ST_CAPTURE = 3'b000,
      ST_TIMEOUT = 3'b001,
      ST_EXTRA   = 3'b011,
      ST_STAB    = 3'b010,
      ST_RUN     = 3'b110,
      ST_SLEEP   = 3'b111
   } phase_e;

   localparam int NPIN = 12;

   logic [NPIN-1:0] pin_meta;      // First synchroniser stage, read only by the second.
   logic [NPIN-1:0] pin_sync;      // Second synchroniser stage.
   logic [2:0]      osc_prev;      // Delayed copies for edge detection.
   logic            sys_edge;      // Rising edge of the selected oscillator.
   logic            wdt_edge;      // Rising edge of the watchdog oscillator.
   logic            asy_edge;      // Rising edge of the async timer oscillator.
   logic            wake_sync;     // Wake request level.
   logic            int_sync;      // External interrupt level.
   fuse_s           fuse_sync;     // Synchronised fuse pins.
   fuse_s           fuse;          // Fuses caught after reset release.
   phase_e          phase;         // Sequencer state.
   logic [15:0]     count;         // Phase cycle counter.
   source_e         source;        // Decoded clock source.
   logic [15:0]     stab_cycles;   // Stabilisation length.
   logic [13:0]     tout_cycles;   // Time-out length in watchdog cycles.
   logic [2:0]      div_count;     // System clock prescaler.
   logic            sys_tick;      // One pulse per system clock period.
   logic [4:0]      gate;          // Per-domain gate bits.
   logic            run;           // Core side may run.
   logic            sleep_req;     // Software asks for power-down.
   logic            int_prev;      // Previous interrupt level for edge capture.
   logic            int_clear;     // Software clears the interrupt flag.

   // Pins pass two flops; fuses are pins too, caught only once stable.
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         pin_meta <= '0;
         pin_sync <= '0;
         osc_prev <= '0;
      end else begin
         pin_meta <= {EXT_INT_IN, WAKE_IN, ASY_OSC_IN, WDT_OSC_IN, SYS_OSC_IN, FUSE_IN};
         pin_sync <= pin_meta;
         osc_prev <= pin_sync[9:7];
      end
   end

   assign fuse_sync = pin_sync[6:0];
   assign sys_edge  = pin_sync[7] & ~osc_prev[0];
   assign wdt_edge  = pin_sync[8] & ~osc_prev[1];
   assign asy_edge  = pin_sync[9] & ~osc_prev[2];
   assign wake_sync = pin_sync[10];
   assign int_sync  = pin_sync[11];

   // Source decode by the four select bits; reserved falls back to external timing.
   always_comb begin
      unique casez (fuse.clock_source_select_fuses)
         4'b1???: source = SRC_LOW_POWER;
         4'b011?: source = SRC_FULL_SWNG;
         4'b010?: source = SRC_LOW_FREQ;
         SEL_RC_128K:  source = SRC_RC_128K;
         SEL_CAL_RC:   source = SRC_CAL_RC;
         SEL_RESERVED: source = SRC_RESERVED;
         default:      source = SRC_EXTERNAL;
      endcase
   end

   // Stabilisation and time-out lengths from the select low bit and start-up code.
   always_comb begin
      stab_cycles = STAB_EXT;
      tout_cycles = 14'(TOUT_LONG);
      unique case ({fuse.clock_source_select_fuses[0], fuse.startup_time_fuses})
         3'b000: tout_cycles = 14'(TOUT_SHORT);
         3'b001: tout_cycles = 14'(TOUT_LONG);
         3'b010: tout_cycles = 14'(TOUT_NONE_CYCLES);
         3'b011: tout_cycles = 14'(TOUT_SHORT);
         3'b100: tout_cycles = 14'(TOUT_LONG);
         3'b101: tout_cycles = 14'(TOUT_NONE_CYCLES);
         3'b110: tout_cycles = 14'(TOUT_SHORT);
         3'b111: tout_cycles = 14'(TOUT_LONG);
      endcase
      if (source == SRC_LOW_POWER || source == SRC_FULL_SWNG) begin
         unique case ({fuse.clock_source_select_fuses[0], fuse.startup_time_fuses})
            3'b000, 3'b001: stab_cycles = STAB_258;
            3'b010, 3'b011: stab_cycles = STAB_1K;
            3'b100:         stab_cycles = STAB_1K;
            default:        stab_cycles = STAB_16K;
         endcase
      end else if (source == SRC_LOW_FREQ) begin
         // Low-frequency crystal: 1K or 32K, time-out by start-up code.
         stab_cycles = fuse.clock_source_select_fuses[0] ? STAB_32K : STAB_1K;
         unique case (fuse.startup_time_fuses)
            2'h0:    tout_cycles = 14'(TOUT_NONE_CYCLES);
            2'h1:    tout_cycles = 14'(TOUT_SHORT);
            default: tout_cycles = 14'(TOUT_LONG);           // Reserved code takes longest.
         endcase
      end else begin
         // External and RC sources: shortest stabilisation, code picks time-out.
         unique case (fuse.startup_time_fuses)
            2'h0:    tout_cycles = 14'(TOUT_NONE_CYCLES);
            2'h1:    tout_cycles = 14'(TOUT_SHORT);
            default: tout_cycles = 14'(TOUT_LONG);
         endcase
      end
   end

   // Start-up sequencer: catch fuses, time out, add 14 cycles, stabilise, run, sleep.
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         phase <= ST_CAPTURE;
         count <= '0;
         fuse  <= FUSE_DEFAULT;
      end else begin
         unique case (phase)
            ST_CAPTURE: begin
               // Fuses are caught after release, so the strap is never an async load.
               // The synchroniser was cleared by reset, so wait until it holds the pins.
               if (count[1:0] == 2'h2) begin
                  fuse  <= fuse_sync;
                  count <= '0;
                  phase <= ST_TIMEOUT;
               end else begin
                  count <= count + 16'h0001;
               end
            end
            ST_TIMEOUT: begin
               // Zero-length time-out skips straight on; a brown-out monitor must cover it.
               if (count[13:0] >= tout_cycles) begin
                  count <= '0;
                  phase <= ST_EXTRA;
               end else if (wdt_edge) begin
                  count <= count + 16'h0001;
               end
            end
            ST_EXTRA: begin
               if (count >= 16'(EXTRA_CK_CYCLES)) begin
                  count <= '0;
                  phase <= ST_STAB;
               end else if (sys_edge) begin
                  count <= count + 16'h0001;
               end
            end
            ST_STAB: begin
               if (sys_edge && count == stab_cycles - 16'h0001) begin
                  count <= '0;
                  phase <= ST_RUN;
               end else if (sys_edge) begin
                  count <= count + 16'h0001;
               end
            end
            ST_RUN: begin
               if (sleep_req) begin
                  phase <= ST_SLEEP;
               end
            end
            ST_SLEEP: begin
               // Wake skips the time-out: supply is assumed still good.
               if (wake_sync) begin
                  count <= '0;
                  phase <= ST_STAB;
               end
            end
            default: phase <= ST_CAPTURE;
         endcase
      end
   end

   assign run = (phase == ST_RUN);

   // System clock prescaler; a stored zero means divide-by-eight is programmed.
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         div_count <= '0;
      end else if (sys_edge) begin
         div_count <= (div_count == DIV8_LAST) ? 3'h0 : div_count + 3'h1;
      end
   end

   assign sys_tick = sys_edge & (fuse.divide_by_eight_fuse |
                                 (div_count == DIV8_LAST));

   // Register writes: gate bits and power control.
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         gate      <= GATE_RESET;
         sleep_req <= 1'b0;
         int_clear <= 1'b0;
      end else begin
         sleep_req <= WR_EN && ADDR == REG_POWER_CTRL && WR_DATA[PWR_SLEEP];
         int_clear <= WR_EN && ADDR == REG_POWER_CTRL && WR_DATA[PWR_CLEAR_INT];
         if (WR_EN && ADDR == REG_CLOCK_GATE) begin
            gate <= WR_DATA[4:0];
         end
      end
   end

   // Domain enables; each has its own gate bit, pulses last one CLK cycle.
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         CORE_CLK_EN   <= 1'b0;
         PERIPH_CLK_EN <= 1'b0;
         FLASH_CLK_EN  <= 1'b0;
         ASYNC_CLK_EN  <= 1'b0;
         CONV_CLK_EN   <= 1'b0;
      end else begin
         CORE_CLK_EN   <= sys_tick & run & gate[GATE_CORE];
         PERIPH_CLK_EN <= sys_tick & run & gate[GATE_PERIPH];
         FLASH_CLK_EN  <= sys_tick & run & gate[GATE_CORE] & gate[GATE_FLASH];
         // The async timer ignores sleep so it can keep real time.
         ASYNC_CLK_EN  <= asy_edge & gate[GATE_ASYNC];
         // Converter runs in sleep too, the point of a quiet conversion.
         CONV_CLK_EN   <= sys_tick & (run | phase == ST_SLEEP) & gate[GATE_CONV];
      end
   end

   // Async interrupt capture works without the peripheral enable; set beats clear.
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         int_prev          <= 1'b0;
         ASYNC_INT_PENDING <= 1'b0;
      end else begin
         int_prev <= int_sync;
         if (int_sync && !int_prev) begin
            ASYNC_INT_PENDING <= 1'b1;
         end else if (int_clear) begin
            ASYNC_INT_PENDING <= 1'b0;
         end
      end
   end

   // Internal reset and oscillator range outputs.
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         INTERNAL_RESET_N <= 1'b0;
         OSC_RANGE        <= 2'h0;
      end else begin
         INTERNAL_RESET_N <= (phase == ST_RUN) | (phase == ST_SLEEP);
         // Range 0 is the lowest mode; fit it only with ceramic resonators.
         OSC_RANGE <= (source == SRC_LOW_POWER) ?
                      2'(fuse.clock_source_select_fuses[3:1] - MODE_LP_LOWEST) :
                      2'h0;
      end
   end

   // Read data stand in the cycle after the strobe and return to zero after.
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         RD_DATA <= '0;
      end else if (RD_EN) begin
         unique case (ADDR)
            REG_CLOCK_GATE: RD_DATA <= {3'h0, gate};
            REG_POWER_CTRL: RD_DATA <= 8'h00;
            REG_STATUS:     RD_DATA <= {ASYNC_INT_PENDING, source, 1'b0, phase};
            REG_FUSE_VIEW:  RD_DATA <= {1'b0, fuse};
         endcase
      end else begin
         RD_DATA <= '0;
      end
   end

endmodule

// file: tb/osc_source.sv
// Purpose: Far-side oscillators: selected system source, watchdog and async timer crystal.
// Assumes: Periods are scaled so that CLK samples every level cleanly.
// Notes:   Sources run free; only the watchdog can be stopped, to show it is not awaited.
`timescale 1ns/1ps
module osc_source #(
   parameter int SYS_HALF = 50,
   parameter int WDT_HALF = 150,
   parameter int ASY_HALF = 100
) (
   // Control from the bench.
   input  wire logic wdt_run,
   // Oscillator pins.
   output logic      sys_osc,
   output logic      wdt_osc,
   output logic      asy_osc
);
   // System source: a resonator, the only part fit for the lowest crystal mode.
   initial begin
      sys_osc = 1'b0;
      #3;
      forever #SYS_HALF sys_osc = ~sys_osc;
   end
   // Watchdog oscillator; it holds its level while stopped.
   initial begin
      wdt_osc = 1'b0;
      forever #WDT_HALF wdt_osc = wdt_run ? ~wdt_osc : wdt_osc;
   end
   // Timer crystal keeps running in every mode, scaled up from 32kHz.
   initial begin
      asy_osc = 1'b0;
      #7;
      forever #ASY_HALF asy_osc = ~asy_osc;
   end
endmodule

// file: tb/clock_checker_assertions.sv
// Purpose: Assertions on start-up sequencing and domain enables.
// Assumes: Fuse pins change only while RST_N is low.
// Notes:   Oscillator edges are counted raw, so counts give lower bounds only.
`timescale 1ns/1ps
module clock_checker
   import clock_startup_pkg::*;
#(
   parameter int TOUT_SHORT = 512
) (
   // Clock and reset.
   input wire logic       CLK,
   input wire logic       RST_N,
   // Pins watched.
   input wire logic       SYS_OSC_IN,
   input wire logic       WDT_OSC_IN,
   input wire logic       ASY_OSC_IN,
   input wire logic       EXT_INT_IN,
   input wire fuse_s      FUSE_IN,
   // Outputs watched.
   input wire logic       INTERNAL_RESET_N,
   input wire logic       CORE_CLK_EN,
   input wire logic       PERIPH_CLK_EN,
   input wire logic       FLASH_CLK_EN,
   input wire logic       ASYNC_CLK_EN,
   input wire logic       CONV_CLK_EN,
   input wire logic       ASYNC_INT_PENDING,
   input wire logic [1:0] OSC_RANGE
);
   logic [15:0] sys_n; // Oscillator edges since reset, saturating.
   logic [15:0] wdt_n; // Watchdog edges since reset, saturating.
   logic [3:0]  gap;   // Oscillator edges since the last converter pulse.
   logic        seen;  // A converter pulse has been seen.
   logic        sys_q; // Oscillator level one cycle ago.
   logic        wdt_q; // Watchdog level one cycle ago.
   // Edge counters; the design sees edges later than these do, never earlier.
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         {sys_n, wdt_n, sys_q, wdt_q} <= '0;
      end else begin
         sys_q <= SYS_OSC_IN;
         wdt_q <= WDT_OSC_IN;
         if (SYS_OSC_IN && !sys_q && sys_n != 16'hffff) sys_n <= sys_n + 16'h1;
         if (WDT_OSC_IN && !wdt_q && wdt_n != 16'hffff) wdt_n <= wdt_n + 16'h1;
      end
   end
   // Spacing of converter pulses in oscillator edges.
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         {gap, seen} <= '0;
      end else if (CONV_CLK_EN) begin
         gap  <= 4'h0;
         seen <= 1'b1;
      end else if (SYS_OSC_IN && !sys_q && gap != 4'hf) begin
         gap <= gap + 4'h1;
      end
   end
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_N);
   core_after_reset_a: assert property (CORE_CLK_EN |-> INTERNAL_RESET_N)
      else $error("core enable while held in reset");
   periph_after_reset_a: assert property (PERIPH_CLK_EN |-> INTERNAL_RESET_N)
      else $error("peripheral enable while held in reset");
   ext_int_a: assert property ($rose(EXT_INT_IN) |-> ##[1:5] ASYNC_INT_PENDING)
      else $error("external event not latched");
   flash_with_core_a: assert property (FLASH_CLK_EN |-> CORE_CLK_EN)
      else $error("flash enable without core enable");
   async_follows_osc_a: assert property ($rose(ASY_OSC_IN) |-> ##[1:5] ASYNC_CLK_EN)
      else $error("async enable missing after timer edge");
   conv_after_reset_a: assert property (CONV_CLK_EN |-> INTERNAL_RESET_N)
      else $error("converter enable while held in reset");
   tout_count_a: assert property ($rose(INTERNAL_RESET_N) && !FUSE_IN.clock_source_select_fuses[3]
      && !FUSE_IN.clock_source_select_fuses[2] && FUSE_IN.startup_time_fuses != 2'h0
      |-> wdt_n >= TOUT_SHORT) else $error("reset released before time-out");
   stab_count_a: assert property ($rose(INTERNAL_RESET_N) |-> sys_n >= 16'd20)
      else $error("reset released before stabilisation");
   osc_range_a: assert property (INTERNAL_RESET_N |-> OSC_RANGE ==
      (FUSE_IN.clock_source_select_fuses[3] ? FUSE_IN.clock_source_select_fuses[2:1] : 2'h0))
      else $error("frequency mode wrong");
   div8_gap_a: assert property (CONV_CLK_EN && seen && !FUSE_IN.divide_by_eight_fuse
      |-> gap >= 4'd7) else $error("divided ticks too close");
endmodule
bind clock_source_startup_control clock_checker #(.TOUT_SHORT(TOUT_SHORT)) clock_checker_i (.*);

// file: tb/clock_source_startup_control_tb.sv
// Purpose: Self-checking bench for clock source decode, start-up and domain gating.
// Assumes: Time-out counts shortened to 4 and 16 watchdog cycles.
// Notes:   Sequence lengths are derived from oscillator edges at 5 CLK cycles each.
`timescale 1ns/1ps
module clock_source_startup_control_tb
   import clock_startup_pkg::*;
   ;
   logic CLK, RST_N, WAKE_IN, EXT_INT_IN, WR_EN, RD_EN, wdt_run;   // Bench-driven controls.
   logic SYS_OSC_IN, WDT_OSC_IN, ASY_OSC_IN;                       // From the oscillator model.
   fuse_s       FUSE_IN;                                            // Fuse pins.
   logic [1:0]  ADDR, OSC_RANGE;                                    // Address and mode.
   logic [7:0]  WR_DATA, RD_DATA, v;                                // Register data.
   logic        INTERNAL_RESET_N, CORE_CLK_EN, PERIPH_CLK_EN, FLASH_CLK_EN;
   logic        ASYNC_CLK_EN, CONV_CLK_EN, ASYNC_INT_PENDING;
   int          fail_count, checks, cycles, t, lo, n_core, n_per, n_fl, n_conv, n_asy;
   logic [3:0]  cks [5] = '{4'h8, 4'ha, 4'hc, 4'he, 4'h9};           // Low-power crystal codes.
   clock_source_startup_control #(.TOUT_SHORT(4), .TOUT_LONG(16))
      clock_source_startup_control_i (.*);
   osc_source osc_source_i (.wdt_run(wdt_run), .sys_osc(SYS_OSC_IN), .wdt_osc(WDT_OSC_IN),
      .asy_osc(ASY_OSC_IN));
   // Clock at 50 MHz.
   always #10 CLK = ~CLK;
   // Pulse counters and the hang guard.
   always @(posedge CLK) begin
      cycles++;
      n_core += int'(CORE_CLK_EN === 1'b1);
      n_per  += int'(PERIPH_CLK_EN === 1'b1);
      n_fl   += int'(FLASH_CLK_EN === 1'b1);
      n_conv += int'(CONV_CLK_EN === 1'b1);
      n_asy  += int'(ASYNC_CLK_EN === 1'b1);
      if (cycles == 40000) begin
         fail_count++;
         final_report();
      end
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         $display("ERROR %0t: value %h expected %h", $time, got, exp);
         fail_count++;
      end
   endtask
   task automatic span(input int got, input int a, input int b);
      checks++;
      if (got < a || got > b) begin
         $display("ERROR %0t: count %0d outside %0d..%0d", $time, got, a, b);
         fail_count++;
      end
   endtask
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge CLK);
      ADDR    <= a;
      WR_DATA <= d;
      WR_EN   <= 1'b1;
      @(posedge CLK);
      WR_EN <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe.
   task automatic rd(input logic [1:0] a, output logic [7:0] d);
      @(posedge CLK);
      ADDR  <= a;
      RD_EN <= 1'b1;
      @(posedge CLK);
      RD_EN <= 1'b0;
      #1 d = RD_DATA;
   endtask
   // Reset with new fuses, then count cycles until the internal reset lets go.
   task automatic boot(input fuse_s f);
      RST_N   <= 1'b0;
      FUSE_IN <= f;
      repeat (6) @(posedge CLK);
      RST_N <= 1'b1;
      t = 0;
      while (INTERNAL_RESET_N !== 1'b1 && t < 8000) begin
         @(posedge CLK);
         t++;
      end
   endtask
   task automatic window(input int n);
      #1 {n_core, n_per, n_fl, n_conv, n_asy} = '0;
      repeat (n) @(posedge CLK);
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   initial begin
      {CLK, RST_N, WAKE_IN, EXT_INT_IN, WR_EN, RD_EN, ADDR, WR_DATA} = '0;
      {fail_count, checks, cycles} = '0;
      wdt_run = 1'b1;
      FUSE_IN = FUSE_DEFAULT;
      // Shipped fuses: calibrated RC, long time-out, divided clock.
      boot(FUSE_DEFAULT);
      rd(REG_STATUS, v);
      chk(v, 8'h26);
      rd(REG_FUSE_VIEW, v);
      chk(v, 8'h22);
      rd(REG_CLOCK_GATE, v);
      chk(v, {3'h0, GATE_RESET});
      rd(REG_POWER_CTRL, v);
      chk(v, 8'h00);
      window(400);
      span(n_core, 9, 11);
      span(n_fl, 9, 11);
      $display("test defaults done");
      // External clock, no time-out as a brown-out detector is assumed, undivided.
      boot('{1'b1, 2'h0, SEL_EXTERNAL});
      span(t, (EXTRA_CK_CYCLES + int'(STAB_EXT) - 1) * 5, 150);
      rd(REG_STATUS, v);
      chk(v, 8'h06);
      wr(REG_FUSE_VIEW, 8'h00);
      rd(REG_FUSE_VIEW, v);
      chk(v, 8'h40);
      wr(REG_CLOCK_GATE, 8'h1a);
      repeat (2) @(posedge CLK);
      window(400);
      span(n_core + n_fl, 0, 0);
      span(n_per, 79, 81);
      wr(REG_CLOCK_GATE, 8'h1f);
      wr(REG_POWER_CTRL, 8'h01);
      repeat (2) @(posedge CLK);
      window(200);
      span(n_core + n_per, 0, 0);
      span(n_conv, 39, 41);
      span(n_asy, 19, 21);
      EXT_INT_IN <= 1'b1;
      repeat (3) @(posedge CLK);
      EXT_INT_IN <= 1'b0;
      rd(REG_STATUS, v);
      chk(v, 8'h87);
      wdt_run <= 1'b0;
      WAKE_IN <= 1'b1;
      t = 0;
      while (CORE_CLK_EN !== 1'b1 && t < 300) begin
         @(posedge CLK);
         t++;
      end
      WAKE_IN <= 1'b0;
      wdt_run <= 1'b1;
      span(t, 1, 100);
      wr(REG_POWER_CTRL, 8'h02);
      rd(REG_STATUS, v);
      chk(v, 8'h06);
      $display("test gating and sleep done");
      // Low-power crystal modes with start-up code 00.
      for (int i = 0; i < 5; i++) begin
         boot('{1'b1, 2'h0, cks[i]});
         lo = (EXTRA_CK_CYCLES + int'(cks[i][0] ? STAB_1K : STAB_258) - 1) * 5;
         span(t, lo, lo + 300);
         chk({6'h0, OSC_RANGE}, {5'h0, cks[i][3:1] - MODE_LP_LOWEST});
         rd(REG_STATUS, v);
         chk(v, 8'h66);
      end
      $display("test crystal modes done");
      final_report();
   end
endmodule
